// >>> dram_edo_cfg.svh
// Operation
// - EDO read data captured one cycle later
// - EDO select picks ordinary or EDO timing
// - EDO reads drive output enable strobe
// - Single DMA writes wait before column strobe
// - Distributed refresh when mode 0, enable 1
// - Mode 1 and enable 1 start self-refresh
// - Counter counts on from its present value
// - Counter match requests repeated refreshes
// - Counter match clears counter and keeps counting
// - Refresh row active length from control field
// - Refresh precharge uses ordinary precharge setting
// - Self-refresh blocks DRAM access and arbitration
// - Clearing mode select leaves self-refresh
// - Auto-refresh resumes after self-refresh exit
// - Self-refresh held through standby and NMI
// - Power-on reset clears registers and self-refresh
// - Burst ROM keeps select, skips setup later
// - Nibble reads only for listed sizes, two
// - Burst ROM wait sampling, zero-wait two cycles
`ifndef DRAM_EDO_CFG_SVH
`define DRAM_EDO_CFG_SVH
`define OFS_MEM_CTRL      8'h00
`define OFS_BUS_CTRL_ONE  8'h04
`define OFS_BUS_CTRL_TRE  8'h08
`define OFS_REF_TMR_CTRL  8'h0c
`define OFS_REF_COUNTER   8'h10
`define OFS_REF_CONSTANT  8'h14
`define OFS_STATUS        8'h18
`define MEMCTL_EDO_BIT    0
`define MEMCTL_MODE_BIT   1
`define MEMCTL_ENA_BIT    2
`define MEMCTL_RAS_LO     3
`define MEMCTL_TRP_LO     5
`define BCONE_BROM_BIT    0
`define BCONE_ROM16_BIT   1
`define BCTRE_STW_LO      0
`define BCTRE_RWAIT_LO    2
`define RTMR_CSEL_LO      0
`define RTMR_REP_LO       3
`define RST_REG8          8'h00
`define ROM_MAX_BEATS     2'h2
`endif

// >>> dram_edo_pkg.sv
package dram_edo_pkg;
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_PRE     = 4'b0001,
    ST_RAS     = 4'b0010,
    ST_DSW     = 4'b0011,
    ST_CAS     = 4'b0100,
    ST_DATA    = 4'b0101,
    ST_REF_CAS = 4'b0110,
    ST_REF_RAS = 4'b0111,
    ST_SELF    = 4'b1000,
    ST_ROM_T1  = 4'b1001,
    ST_ROM_T2  = 4'b1010,
    ST_ROM_TN  = 4'b1011
  } ctrl_state_t;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10
  } acc_size_t;
endpackage

// >>> dram_edo_refresh_burst_rom_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "dram_edo_cfg.svh"
module dram_edo_refresh_burst_rom_ctrl #(
  parameter int DW = 32
) (
  input  wire logic          sys_clk,
  input  wire logic          reset,
  input  wire logic [7:0]    regAddr,
  input  wire logic [7:0]    regWrData,
  input  wire logic          regWr,
  input  wire logic          regRd,
  output logic [7:0]         regRdData,
  input  wire logic          dramReq,
  input  wire logic          dramWrite,
  input  wire logic          dmaSingle,
  input  wire logic [DW-1:0] dramDataIn,
  input  wire logic          romReq,
  input  wire logic [1:0]    romSize,
  input  wire logic          waitPinN,
  output logic               rowStrobeN,
  output logic               columnStrobeN,
  output logic               outputEnableN,
  output logic               dmaAcknowledgeN,
  output logic               bootChipSelectN,
  output logic [1:0]         romNibbleAddr,
  output logic               accessDone,
  output logic [DW-1:0]      readData,
  output logic               romBeat,
  output logic               busArbEnable,
  output logic               selfRefreshActive
);
  dram_edo_pkg::ctrl_state_t state_ff, nxt_state;
  logic [7:0]    memCtrl_ff, busCtrlOne_ff, busCtrlTre_ff, refTmrCtrl_ff;
  logic [7:0]    refreshCnt_ff, refreshConst_ff, regRdData_ff;
  logic [15:0]   presc_ff;
  logic [3:0]    refPending_ff, nxt_refPending;
  logic [2:0]    cnt_ff, nxt_cnt;
  logic          accPend_ff, isWrite_ff, isDma_ff;
  logic [1:0]    beatsLeft_ff, nxt_beatsLeft, romAddr_ff;
  logic          waitMeta_ff, waitSync_ff;
  logic [DW-1:0] dataMeta_ff, dataSync_ff, readData_ff;
  logic [1:0]    capPipe_ff;
  logic          rasN_ff, column_strobe_ff, oeN_ff, dma_acknowledge_ff, csN_ff;
  logic          done_ff, beat_ff, arbEn_ff, self_ff;

  wire edoSel   = memCtrl_ff[`MEMCTL_EDO_BIT];
  wire refMode  = memCtrl_ff[`MEMCTL_MODE_BIT];
  wire refEna   = memCtrl_ff[`MEMCTL_ENA_BIT];
  wire [1:0] rasCyc  = memCtrl_ff[`MEMCTL_RAS_LO +: 2];
  wire [1:0] trpCyc  = memCtrl_ff[`MEMCTL_TRP_LO +: 2];
  wire burstRom = busCtrlOne_ff[`BCONE_BROM_BIT];
  wire rom16    = busCtrlOne_ff[`BCONE_ROM16_BIT];
  wire [1:0] stWait  = busCtrlTre_ff[`BCTRE_STW_LO +: 2];
  wire [1:0] romWait = busCtrlTre_ff[`BCTRE_RWAIT_LO +: 2];
  wire [2:0] clkSel  = refTmrCtrl_ff[`RTMR_CSEL_LO +: 3];
  wire [2:0] repCnt  = refTmrCtrl_ff[`RTMR_REP_LO +: 3];

  // Register decode
  wire wrMem   = regWr && (regAddr == `OFS_MEM_CTRL);
  wire wrOne   = regWr && (regAddr == `OFS_BUS_CTRL_ONE);
  wire wrTre   = regWr && (regAddr == `OFS_BUS_CTRL_TRE);
  wire wrTmr   = regWr && (regAddr == `OFS_REF_TMR_CTRL);
  wire wrCnt   = regWr && (regAddr == `OFS_REF_COUNTER);
  wire wrConst = regWr && (regAddr == `OFS_REF_CONSTANT);
  wire [7:0] statusWord = {refPending_ff, state_ff};
  wire [7:0] rdMux =
    (regAddr == `OFS_MEM_CTRL)     ? memCtrl_ff      :
    (regAddr == `OFS_BUS_CTRL_ONE) ? busCtrlOne_ff   :
    (regAddr == `OFS_BUS_CTRL_TRE) ? busCtrlTre_ff   :
    (regAddr == `OFS_REF_TMR_CTRL) ? refTmrCtrl_ff   :
    (regAddr == `OFS_REF_COUNTER)  ? refreshCnt_ff   :
    (regAddr == `OFS_REF_CONSTANT) ? refreshConst_ff :
    (regAddr == `OFS_STATUS)       ? statusWord      : `RST_REG8;

  // Prescaler tick: clock select 0 stops, n divides by 4^n
  wire [15:0] prescMask = 16'(((17'h1 << {clkSel, 1'b0}) - 17'h1));
  wire tick  = (clkSel != 3'h0) && ((presc_ff & prescMask) == prescMask);
  wire match = tick && (refreshCnt_ff == refreshConst_ff);
  wire [3:0] reps    = (repCnt == 3'h0) ? 4'h1 : {1'b0, repCnt};
  wire       refAuto = refEna && !refMode;
  wire       selfReq = refEna && refMode;
  wire       romNib  = (!rom16 && romSize != dram_edo_pkg::SZ_BYTE) ||
                       (rom16 && romSize == dram_edo_pkg::SZ_LONG);
  wire       romWaitActive = (romWait != 2'h0) && !waitSync_ff;
  wire       refTake = (state_ff == dram_edo_pkg::ST_REF_CAS);
  wire       captureNow = !isWrite_ff &&
    ((!edoSel && state_ff == dram_edo_pkg::ST_CAS) ||
     (edoSel && state_ff == dram_edo_pkg::ST_DATA));

  always_comb begin
    nxt_refPending = refPending_ff - (refTake ? 4'h1 : 4'h0);
    if (match && refAuto) begin
      nxt_refPending = nxt_refPending + reps;
    end
  end

  always_comb begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    nxt_beatsLeft = beatsLeft_ff;
    case (state_ff)
      dram_edo_pkg::ST_IDLE: begin
        if (selfReq) begin
          nxt_state = dram_edo_pkg::ST_SELF;
        end else if (refAuto && refPending_ff != 4'h0) begin
          nxt_state = dram_edo_pkg::ST_REF_CAS;
        end else if (dramReq) begin
          nxt_state = dram_edo_pkg::ST_PRE;
          nxt_cnt   = {1'b0, trpCyc};
        end else if (romReq) begin
          nxt_state     = dram_edo_pkg::ST_ROM_T1;
          nxt_beatsLeft = (burstRom && romNib) ? `ROM_MAX_BEATS : 2'h1;
        end
      end
      dram_edo_pkg::ST_PRE: begin
        if (cnt_ff != 3'h0) begin
          nxt_cnt = cnt_ff - 3'h1;
        end else if (accPend_ff) begin
          nxt_state = dram_edo_pkg::ST_RAS;
        end else begin
          nxt_state = dram_edo_pkg::ST_IDLE;
        end
      end
      dram_edo_pkg::ST_RAS: begin
        if (isWrite_ff && isDma_ff && stWait != 2'h0) begin
          nxt_state = dram_edo_pkg::ST_DSW;
          nxt_cnt   = {1'b0, stWait} - 3'h1;
        end else begin
          nxt_state = dram_edo_pkg::ST_CAS;
        end
      end
      dram_edo_pkg::ST_DSW: begin
        if (cnt_ff != 3'h0) begin
          nxt_cnt = cnt_ff - 3'h1;
        end else begin
          nxt_state = dram_edo_pkg::ST_CAS;
        end
      end
      dram_edo_pkg::ST_CAS: begin
        nxt_state = dram_edo_pkg::ST_DATA;
      end
      dram_edo_pkg::ST_DATA: begin
        nxt_state = dram_edo_pkg::ST_IDLE;
      end
      dram_edo_pkg::ST_REF_CAS: begin
        nxt_state = dram_edo_pkg::ST_REF_RAS;
        nxt_cnt   = {1'b0, rasCyc};
      end
      dram_edo_pkg::ST_REF_RAS: begin
        if (cnt_ff != 3'h0) begin
          nxt_cnt = cnt_ff - 3'h1;
        end else begin
          nxt_state = dram_edo_pkg::ST_PRE;
          nxt_cnt   = {1'b0, trpCyc};
        end
      end
      dram_edo_pkg::ST_SELF: begin
        // Only a cleared mode bit or reset ends it; standby leaves it alone
        if (!refMode) begin
          nxt_state = dram_edo_pkg::ST_PRE;
          nxt_cnt   = {1'b0, trpCyc};
        end
      end
      dram_edo_pkg::ST_ROM_T1: begin
        nxt_state = dram_edo_pkg::ST_ROM_T2;
        nxt_cnt   = {1'b0, romWait};
      end
      dram_edo_pkg::ST_ROM_T2: begin
        if (cnt_ff != 3'h0) begin
          nxt_cnt = cnt_ff - 3'h1;
        end else if (romWaitActive) begin
          nxt_state = dram_edo_pkg::ST_ROM_T2;
        end else begin
          nxt_beatsLeft = beatsLeft_ff - 2'h1;
          if (beatsLeft_ff == 2'h1) begin
            nxt_state = dram_edo_pkg::ST_IDLE;
          end else if (romWait == 2'h0) begin
            nxt_state = dram_edo_pkg::ST_ROM_TN;
          end else begin
            nxt_cnt = {1'b0, romWait};
          end
        end
      end
      dram_edo_pkg::ST_ROM_TN: begin
        nxt_state = dram_edo_pkg::ST_ROM_T2;
      end
      default: begin
        nxt_state = dram_edo_pkg::ST_IDLE;
      end
    endcase
  end

  // Pin-level strobes decoded from the next state
  wire nRasOn = (nxt_state == dram_edo_pkg::ST_RAS) || (nxt_state == dram_edo_pkg::ST_DSW) ||
                (nxt_state == dram_edo_pkg::ST_CAS) || (nxt_state == dram_edo_pkg::ST_REF_RAS) ||
                (nxt_state == dram_edo_pkg::ST_SELF);
  wire nCasOn = (nxt_state == dram_edo_pkg::ST_CAS) || (nxt_state == dram_edo_pkg::ST_REF_CAS) ||
                (nxt_state == dram_edo_pkg::ST_REF_RAS) || (nxt_state == dram_edo_pkg::ST_SELF);
  wire nRdAcc = accPend_ff ? !isWrite_ff : !dramWrite;
  wire nOeOn  = edoSel && nRdAcc &&
                ((nxt_state == dram_edo_pkg::ST_CAS) || (nxt_state == dram_edo_pkg::ST_DATA));
  // Only the latched access type counts; a held request line must not leak into later cycles
  wire nDack  = isDma_ff &&
                ((nxt_state == dram_edo_pkg::ST_DSW) || (nxt_state == dram_edo_pkg::ST_CAS) ||
                 (nxt_state == dram_edo_pkg::ST_RAS));
  wire nCsOn  = (nxt_state == dram_edo_pkg::ST_ROM_T1) || (nxt_state == dram_edo_pkg::ST_ROM_T2) ||
                (nxt_state == dram_edo_pkg::ST_ROM_TN);
  wire romBeatNow = (state_ff == dram_edo_pkg::ST_ROM_T2) && (cnt_ff == 3'h0) && !romWaitActive;
  wire writeDone  = isWrite_ff && (state_ff == dram_edo_pkg::ST_DATA);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      memCtrl_ff      <= `RST_REG8;
      busCtrlOne_ff   <= `RST_REG8;
      busCtrlTre_ff   <= `RST_REG8;
      refTmrCtrl_ff   <= `RST_REG8;
      refreshConst_ff <= `RST_REG8;
      regRdData_ff    <= `RST_REG8;
    end else begin
      if (wrMem) memCtrl_ff <= regWrData;
      if (wrOne) busCtrlOne_ff <= regWrData;
      if (wrTre) busCtrlTre_ff <= regWrData;
      if (wrTmr) refTmrCtrl_ff <= regWrData;
      if (wrConst) refreshConst_ff <= regWrData;
      regRdData_ff <= regRd ? rdMux : `RST_REG8;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      presc_ff      <= 16'h0000;
      refreshCnt_ff <= `RST_REG8;
      refPending_ff <= 4'h0;
    end else begin
      presc_ff      <= (clkSel == 3'h0) ? 16'h0000 : presc_ff + 16'h0001;
      refPending_ff <= nxt_refPending;
      if (wrCnt) begin
        refreshCnt_ff <= regWrData;
      end else if (match) begin
        refreshCnt_ff <= 8'h00;
      end else if (tick) begin
        refreshCnt_ff <= refreshCnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_ff     <= dram_edo_pkg::ST_IDLE;
      cnt_ff       <= 3'h0;
      beatsLeft_ff <= 2'h0;
      accPend_ff   <= 1'b0;
      isWrite_ff   <= 1'b0;
      isDma_ff     <= 1'b0;
      romAddr_ff   <= 2'h0;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      beatsLeft_ff <= nxt_beatsLeft;
      if (state_ff == dram_edo_pkg::ST_IDLE && nxt_state == dram_edo_pkg::ST_PRE) begin
        accPend_ff <= 1'b1;
        isWrite_ff <= dramWrite;
        isDma_ff   <= dmaSingle;
      end else if (state_ff == dram_edo_pkg::ST_DATA) begin
        accPend_ff <= 1'b0;
        isDma_ff   <= 1'b0;
      end
      if (nxt_state == dram_edo_pkg::ST_ROM_T1) begin
        romAddr_ff  <= 2'h0;
      end else if (romBeatNow) begin
        romAddr_ff <= romAddr_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      waitMeta_ff <= 1'b1;
      waitSync_ff <= 1'b1;
      dataMeta_ff <= '0;
      dataSync_ff <= '0;
      capPipe_ff  <= 2'h0;
      readData_ff <= '0;
    end else begin
      waitMeta_ff <= waitPinN;
      waitSync_ff <= waitMeta_ff;
      dataMeta_ff <= dramDataIn;
      dataSync_ff <= dataMeta_ff;
      // Strobe delayed by the synchroniser depth so it meets the sampled word
      capPipe_ff  <= {capPipe_ff[0], captureNow};
      if (capPipe_ff[1]) readData_ff <= dataSync_ff;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rasN_ff  <= 1'b1;
      column_strobe_ff  <= 1'b1;
      oeN_ff   <= 1'b1;
      dma_acknowledge_ff <= 1'b1;
      csN_ff   <= 1'b1;
      done_ff  <= 1'b0;
      beat_ff  <= 1'b0;
      arbEn_ff <= 1'b1;
      self_ff  <= 1'b0;
    end else begin
      rasN_ff  <= !nRasOn;
      column_strobe_ff  <= !nCasOn;
      oeN_ff   <= !nOeOn;
      dma_acknowledge_ff <= !nDack;
      csN_ff   <= !nCsOn;
      done_ff  <= capPipe_ff[1] || writeDone;
      beat_ff  <= romBeatNow;
      arbEn_ff <= (nxt_state != dram_edo_pkg::ST_SELF);
      self_ff  <= (nxt_state == dram_edo_pkg::ST_SELF);
    end
  end

  assign regRdData         = regRdData_ff;
  assign rowStrobeN        = rasN_ff;
  assign columnStrobeN     = column_strobe_ff;
  assign outputEnableN     = oeN_ff;
  assign dmaAcknowledgeN   = dma_acknowledge_ff;
  assign bootChipSelectN   = csN_ff;
  assign romNibbleAddr     = romAddr_ff;
  assign accessDone        = done_ff;
  assign readData          = readData_ff;
  assign romBeat           = beat_ff;
  assign busArbEnable      = arbEn_ff;
  assign selfRefreshActive = self_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_edo_late;
    (state_ff == dram_edo_pkg::ST_CAS && edoSel && !isWrite_ff) |-> !captureNow ##1 captureNow;
  endproperty
  a_edo_late: assert property (p_edo_late) else $error("EDO capture not delayed");
  property p_oe_only_edo;
    !outputEnableN |-> $past(edoSel);
  endproperty
  a_oe_only_edo: assert property (p_oe_only_edo) else $error("OE driven outside EDO");
  property p_edo_oe_read;
    (state_ff == dram_edo_pkg::ST_CAS && edoSel && !isWrite_ff) |-> !outputEnableN;
  endproperty
  a_edo_oe_read: assert property (p_edo_oe_read) else $error("OE missing in EDO read");
  property p_dsw_wait;
    (state_ff == dram_edo_pkg::ST_RAS && isWrite_ff && isDma_ff && stWait == 2'h1)
      |=> state_ff == dram_edo_pkg::ST_DSW ##1 state_ff == dram_edo_pkg::ST_CAS;
  endproperty
  a_dsw_wait: assert property (p_dsw_wait) else $error("Single write wait wrong");
  property p_match_clear;
    (match && !wrCnt) |=> refreshCnt_ff == 8'h00;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("Counter not cleared");
  property p_match_request;
    (match && refAuto && !refTake) |=> refPending_ff == $past(refPending_ff) + $past(reps);
  endproperty
  a_match_request: assert property (p_match_request) else $error("Refresh not requested");
  property p_ref_ras_len;
    (state_ff == dram_edo_pkg::ST_REF_CAS && rasCyc == 2'h2)
      |=> (state_ff == dram_edo_pkg::ST_REF_RAS) [*3] ##1 state_ff == dram_edo_pkg::ST_PRE;
  endproperty
  a_ref_ras_len: assert property (p_ref_ras_len) else $error("Refresh row time wrong");
  property p_self_no_arb;
    (state_ff == dram_edo_pkg::ST_SELF) |-> !busArbEnable && !rowStrobeN;
  endproperty
  a_self_no_arb: assert property (p_self_no_arb) else $error("Arbitration in self-refresh");
  property p_self_exit;
    (state_ff == dram_edo_pkg::ST_SELF && !refMode) |=> state_ff == dram_edo_pkg::ST_PRE;
  endproperty
  a_self_exit: assert property (p_self_exit) else $error("Self-refresh not left");
  property p_self_hold;
    (state_ff == dram_edo_pkg::ST_SELF && refMode) |=> state_ff == dram_edo_pkg::ST_SELF;
  endproperty
  a_self_hold: assert property (p_self_hold) else $error("Self-refresh dropped");
  property p_rom_beats;
    (state_ff == dram_edo_pkg::ST_ROM_T1) |-> beatsLeft_ff <= `ROM_MAX_BEATS;
  endproperty
  a_rom_beats: assert property (p_rom_beats) else $error("Too many nibble beats");
  property p_rom_zero_wait;
    (romBeatNow && romWait == 2'h0 && beatsLeft_ff == 2'h2)
      |=> state_ff == dram_edo_pkg::ST_ROM_TN ##1 romBeatNow && !bootChipSelectN;
  endproperty
  a_rom_zero_wait: assert property (p_rom_zero_wait) else $error("Zero-wait beat not 2 cycles");
  c_self: cover property (state_ff == dram_edo_pkg::ST_SELF ##1 state_ff == dram_edo_pkg::ST_PRE);
  c_refresh: cover property (refTake ##1 state_ff == dram_edo_pkg::ST_REF_RAS);
  c_edo_read: cover property (capPipe_ff[1] && edoSel);
  c_rom_burst: cover property (romBeatNow && beatsLeft_ff == 2'h1 && romAddr_ff == 2'h1);
endmodule // dram_edo_refresh_burst_rom_ctrl
`default_nettype wire

// >>> dram_rom_partner.sv
`timescale 1ns/1ns
`default_nettype none
module dram_rom_partner #(
  parameter int DW = 32
) (
  input  wire logic          sys_clk,
  input  wire logic          rowStrobeN,
  input  wire logic          columnStrobeN,
  input  wire logic          accessDone,
  input  wire logic          bootChipSelectN,
  input  wire logic [DW-1:0] readWord,
  input  wire logic [7:0]    waitHold,
  output logic [DW-1:0]      dramDataIn,
  output logic               waitPinN
);
  logic          holding = 1'b0;
  logic [DW-1:0] lastWord = '0;
  logic          csPrev = 1'b1;
  logic [7:0]    waitLeft = 8'h00;
  // Word stands from column strobe until completion, then the lines show its inverse
  assign dramDataIn = (holding || (!rowStrobeN && !columnStrobeN)) ? readWord : ~lastWord;
  assign waitPinN   = (waitLeft == 8'h00);
  always @(posedge sys_clk) begin
    if (accessDone) begin
      holding <= 1'b0;
    end else if (!rowStrobeN && !columnStrobeN) begin
      holding  <= 1'b1;
      lastWord <= readWord;
    end
    csPrev <= bootChipSelectN;
    if (csPrev && !bootChipSelectN) begin
      waitLeft <= waitHold;
    end else if (waitLeft != 8'h00) begin
      waitLeft <= waitLeft - 8'h01;
    end
  end
endmodule // dram_rom_partner
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        sys_clk, reset, regWr, regRd, dramReq, dramWrite, dmaSingle, romReq;
  logic [7:0]  regAddr, regWrData, regRdData, waitHold;
  logic [1:0]  romSize, romNibbleAddr;
  logic [31:0] dramDataIn, readData, readWord;
  logic        waitPinN, rowStrobeN, columnStrobeN, outputEnableN, dmaAcknowledgeN;
  logic        bootChipSelectN, accessDone, romBeat, busArbEnable, selfRefreshActive;
  logic        prevRas = 1, prevCas = 1, prevCs = 1;
  int          mismatches = 0, comparisons = 0, cyc = 0, rasFalls = 0, refStarts = 0;
  int          rasRun = 0, lastRas = 0, rasHi = 0, minGap = 99, oeCount = 0, ackWait = 0;
  int          beats = 0, lastBeat = 0, beatGap = 0, csRises = 0, csRun = 0, csLen = 0;
  integer      seed = 32'h886a;
  dram_edo_refresh_burst_rom_ctrl #(.DW(32)) dram_edo_refresh_burst_rom_ctrl_i (
    .sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .dramReq(dramReq),
    .dramWrite(dramWrite), .dmaSingle(dmaSingle), .dramDataIn(dramDataIn),
    .romReq(romReq), .romSize(romSize), .waitPinN(waitPinN), .rowStrobeN(rowStrobeN),
    .columnStrobeN(columnStrobeN), .outputEnableN(outputEnableN),
    .dmaAcknowledgeN(dmaAcknowledgeN), .bootChipSelectN(bootChipSelectN),
    .romNibbleAddr(romNibbleAddr), .accessDone(accessDone), .readData(readData),
    .romBeat(romBeat), .busArbEnable(busArbEnable), .selfRefreshActive(selfRefreshActive));
  dram_rom_partner #(.DW(32)) dram_rom_partner_i (
    .sys_clk(sys_clk), .rowStrobeN(rowStrobeN), .columnStrobeN(columnStrobeN),
    .accessDone(accessDone), .bootChipSelectN(bootChipSelectN), .readWord(readWord),
    .waitHold(waitHold), .dramDataIn(dramDataIn), .waitPinN(waitPinN));
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Pin monitor: runs of strobe levels, refresh starts and ROM beats
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
    prevRas <= rowStrobeN;
    prevCas <= columnStrobeN;
    prevCs  <= bootChipSelectN;
    if (prevRas && !rowStrobeN) rasFalls <= rasFalls + 1;
    if (!rowStrobeN) rasRun <= rasRun + 1;
    else if (rasRun != 0) begin
      lastRas <= rasRun;
      rasRun  <= 0;
    end
    rasHi <= rowStrobeN ? rasHi + 1 : 0;
    if (prevCas && !columnStrobeN && rowStrobeN) begin
      refStarts <= refStarts + 1;
      if (rasHi < minGap) minGap <= rasHi;
    end
    if (!outputEnableN) oeCount <= oeCount + 1;
    if (!dmaAcknowledgeN && columnStrobeN) ackWait <= ackWait + 1;
    if (romBeat) begin
      beats    <= beats + 1;
      beatGap  <= cyc - lastBeat;
      lastBeat <= cyc;
    end
    csRun <= bootChipSelectN ? 0 : csRun + 1;
    if (!prevCs && bootChipSelectN) begin
      csRises <= csRises + 1;
      csLen   <= csRun;
    end
  end
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkFlag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    d = regRdData;
  endtask
  task automatic dramAccess(input logic wr, input logic dma, output logic done);
    @(posedge sys_clk);
    dramReq   <= 1'b1;
    dramWrite <= wr;
    dmaSingle <= dma;
    @(posedge sys_clk);
    dramReq <= 1'b0;
    done = 1'b0;
    for (int k = 0; k < 60 && !done; k++) begin
      @(negedge sys_clk);
      done = (accessDone === 1'b1);
    end
  endtask
  task automatic romRead(input logic [1:0] sz);
    int c0;
    c0 = csRises;
    @(posedge sys_clk);
    romReq  <= 1'b1;
    romSize <= sz;
    @(posedge sys_clk);
    romReq <= 1'b0;
    for (int k = 0; k < 40 && csRises == c0; k++) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    logic [7:0]  d, v, ras;
    logic        done;
    int          b0, c0, exp, len0;
    logic [31:0] expQ[$];
    {regWr, regRd, dramReq, dramWrite, dmaSingle, romReq} = '0;
    {regAddr, regWrData, romSize, waitHold} = '0;
    readWord = '0;
    reset = 1'b1;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chkVal(rasFalls, 0);
    for (int a = 0; a <= 8'h18; a += 4) begin
      rdReg(a[7:0], d);
      chkVal(d, 0);
    end
    v = 8'($random(seed));
    wrReg(8'h10, v);
    rdReg(8'h10, d);
    chkVal(d, v);
    wrReg(8'h1c, 8'hff);
    rdReg(8'h1c, d);
    chkVal(d, 0);
    $display("test registers done");
    for (int e = 0; e < 2; e++) begin
      wrReg(8'h00, (8'($random(seed)) & 8'h78) | 8'(e));
      for (int r = 0; r < 2; r++) begin
        readWord = $random(seed);
        expQ.push_back(readWord);
        b0 = oeCount;
        dramAccess(1'b0, 1'b0, done);
        chkFlag(done, 1'b1);
        chkVal(readData, expQ.pop_front());
        chkFlag(oeCount > b0, e[0]);
      end
    end
    $display("test dram reads done");
    for (int n = 0; n < 4; n++) begin
      wrReg(8'h08, n[7:0]);
      b0 = ackWait;
      dramAccess(1'b1, 1'b1, done);
      chkVal(ackWait - b0, n + 1);
    end
    $display("test dma writes done");
    wrReg(8'h08, 8'h00);
    for (int m = 0; m < 12; m++) begin
      b0 = beats;
      c0 = csRises;
      wrReg(8'h04, {6'h00, m[3], m[2]});
      romRead(2'(m % 3));
      exp = (m[2] && ((!m[3] && m % 3 != 0) || (m[3] && m % 3 == 2))) ? 2 : 1;
      chkVal(beats - b0, exp);
      chkVal(csRises - c0, 1);
      chkVal(romNibbleAddr, exp);
      if (exp == 2) chkVal(beatGap, 2);
      if (exp == 2) len0 = csLen;
    end
    wrReg(8'h04, 8'h01);
    wrReg(8'h08, 8'h04);
    waitHold = 8'h05;
    b0 = beats;
    romRead(2'h2);
    chkVal(beats - b0, 2);
    chkVal(romNibbleAddr, 2);
    chkFlag(csLen > len0, 1'b1);
    waitHold = 8'h00;
    $display("test burst rom done");
    for (int i = 0; i < 3; i++) begin
      ras = i[7:0];
      wrReg(8'h14, 8'h03);
      wrReg(8'h10, 8'h02);
      wrReg(8'h00, 8'h24 | (ras << 3));
      b0 = refStarts;
      minGap = 99;
      wrReg(8'h0c, ((i == 2 ? 8'h03 : ras) << 3) | 8'h01);
      repeat (14) @(posedge sys_clk);
      chkFlag(refStarts > b0, 1'b1);
      repeat (46) @(posedge sys_clk);
      wrReg(8'h0c, 8'h00);
      repeat (100) @(posedge sys_clk);
      chkVal(refStarts - b0, 4 * (i == 2 ? 3 : 1));
      chkVal(lastRas, ras + 1);
      chkFlag(minGap >= 2, 1'b1);
    end
    $display("test refresh done");
    wrReg(8'h0c, 8'h09);
    wrReg(8'h00, 8'h06);
    repeat (10) @(posedge sys_clk);
    chkFlag(selfRefreshActive, 1'b1);
    chkFlag(busArbEnable, 1'b0);
    dramAccess(1'b0, 1'b0, done);
    chkFlag(done, 1'b0);
    wrReg(8'h00, 8'h04);
    repeat (5) @(posedge sys_clk);
    chkFlag(selfRefreshActive, 1'b0);
    b0 = refStarts;
    repeat (40) @(posedge sys_clk);
    chkFlag(refStarts > b0, 1'b1);
    wrReg(8'h00, 8'h06);
    repeat (10) @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chkFlag(selfRefreshActive, 1'b0);
    chkFlag(busArbEnable, 1'b1);
    rdReg(8'h00, d);
    chkVal(d, 0);
    $display("test self refresh done");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
